// File: rtl/awit_pkg.sv
package awit_pkg;

  // bus geometry
  localparam int unsigned BUS_W   = 32;   // wishbone data width
  localparam int unsigned ADDR_W  = 32;   // wishbone address width
  localparam int unsigned SEL_W   = 4;    // byte lane selects
  localparam int unsigned DATA_W  = 8;    // register width
  localparam int unsigned IDX_HI  = 4;    // top word-address bit decoded
  localparam int unsigned IDX_LO  = 2;    // low word-address bit decoded
  localparam int unsigned LANE0   = 0;    // byte lane holding register data

  // register byte offsets
  localparam logic [4:0] OFF_CTRL  = 5'h00;  // timer_reset_control
  localparam logic [4:0] OFF_STAT  = 5'h04;  // overflow status, read-clear
  localparam logic [4:0] OFF_COUNT = 5'h08;  // tick_counter

  // register indices seen on address bits 4:2
  localparam logic [2:0] IDX_CTRL  = OFF_CTRL[4:2];
  localparam logic [2:0] IDX_STAT  = OFF_STAT[4:2];
  localparam logic [2:0] IDX_COUNT = OFF_COUNT[4:2];

  // reset and limit values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [1:0] STAT_RST  = 2'h0;

  // field encodings
  localparam logic MODE_WATCHDOG = 1'b1;  // watchdog_mode_bit = 1
  localparam logic RSEL_MANUAL   = 1'b1;  // reset_type_select = 1

  // prescaler width, wide enough for the largest divisor
  localparam int unsigned PRESC_W = 13;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 13'h0001;
  localparam logic [PRESC_W-1:0] PRESC_RST = 13'h0000;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       irq_enable_bit;     // bit 7
    logic       watchdog_mode_bit;  // bit 6
    logic       count_enable_bit;   // bit 5
    logic       chip_reset_enable;  // bit 4
    logic       reset_type_select;  // bit 3
    logic [2:0] prescale_select;    // bits 2:0
  } awit_ctrl_s;

  // status register layout
  typedef struct packed {
    logic [5:0] zero;               // reads as zero
    logic       interval_ovf;       // bit 1
    logic       watchdog_ovf;       // bit 0
  } awit_stat_s;

  // wishbone slave sequencing
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } awit_bus_e;

  // last prescaler count for a clock-select code (divisor minus one)
  function automatic logic [PRESC_W-1:0] awit_div_last(
    input logic [2:0] sel
  );
    logic [PRESC_W-1:0] last;
    last = 13'h0001;
    case (sel)
      3'h0: last = 13'h0001;  // divide by 2
      3'h1: last = 13'h0007;  // divide by 8
      3'h2: last = 13'h001f;  // divide by 32
      3'h3: last = 13'h003f;  // divide by 64
      3'h4: last = 13'h00ff;  // divide by 256
      3'h5: last = 13'h01ff;  // divide by 512
      3'h6: last = 13'h07ff;  // divide by 2048
      default: last = 13'h1fff;  // divide by 8192
    endcase
    return last;
  endfunction : awit_div_last

endpackage : awit_pkg

// File: rtl/awit_prescaler.sv
`timescale 1ns/1ps
module awit_prescaler #(
  parameter int unsigned W = awit_pkg::PRESC_W  // divider width
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_i,   // count_enable_bit
  input  wire logic [2:0] sel_i,   // prescale_select
  // output
  output logic            tick_o   // one-cycle increment pulse
);

  logic [W-1:0] cnt_q;   // divider count
  logic [W-1:0] cnt_d;
  logic         tick_q;  // registered tick
  logic         tick_d;
  logic [W-1:0] last;    // terminal count for the selected rate

  // next divider state; held at zero while stopped
  always_comb begin
    last   = W'(awit_pkg::awit_div_last(sel_i));
    cnt_d  = awit_pkg::PRESC_RST;
    tick_d = 1'b0;
    if (run_i) begin
      // a code change mid-count may leave cnt above last, so use >=
      if (cnt_q >= last) begin  // see RULE_15
        cnt_d  = awit_pkg::PRESC_RST;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + awit_pkg::PRESC_ONE;
      end
    end
  end

  // divider registers, on the bus clock
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin
      cnt_q  <= awit_pkg::PRESC_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

  // running at divide-by-2
  sequence s_run_div2;
    run_i && sel_i == 3'h0;
  endsequence

  tick_gap_a: assert property (  // see RULE_15
    @(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o)
    else $error("prescaler tick lasted two cycles");

  tick_div2_a: assert property (  // see RULE_15
    @(posedge clk_i) disable iff (rst_i)
    (tick_o ##0 s_run_div2) ##1 s_run_div2 |=> tick_o)
    else $error("divide-by-2 tick period wrong");

endmodule : awit_prescaler

// File: rtl/awit_timer.sv
// Function
// RULE_01 - ignore bus unless this block is selected
// RULE_02 - write enable high writes, low reads
// RULE_03 - master holds address stable through access
// RULE_04 - master holds direction stable through access
// RULE_05 - master ends each access cleanly
// RULE_06 - strobe times every access, answered promptly
// RULE_07 - decode registers from address bits 4:2 only
// RULE_08 - everything clocked by the bus clock
// RULE_09 - reset returns all state to initial values
// RULE_10 - interrupt on watchdog or interval overflow
// RULE_11 - manual reset request on selected overflow
// RULE_12 - power-on reset request on selected overflow
// RULE_13 - watchdog overflow requests a chip reset
// RULE_14 - interval mode interrupts on every overflow
// RULE_15 - select code picks divide 2 to 8192
// RULE_16 - 8-bit up-counter, FF to 00 overflows
// RULE_17 - mode bit and count enable bit
// RULE_18 - reset enable gates, select picks type
// RULE_19 - interrupt enable low keeps interrupt low
// RULE_20 - data bus carries register data both ways
// RULE_21 - counter write takes effect at once
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
module awit_timer (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [awit_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [awit_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [awit_pkg::BUS_W-1:0]   wb_dat_i,
  output logic      [awit_pkg::BUS_W-1:0]   wb_dat_o,
  output logic                              wb_ack_o,
  // requests to the interrupt controller and power manager
  output logic                              timer_irq_o,
  output logic                              manual_reset_request_o,
  output logic                              poweron_reset_request_o
);

  // register index from the word-address bits; upper bits are ignored
  function automatic logic [2:0] reg_index(
    input logic [awit_pkg::ADDR_W-1:0] adr  // full bus address
  );
    return adr[awit_pkg::IDX_HI:awit_pkg::IDX_LO];  // see RULE_07
  endfunction : reg_index

  // bus sequencing state
  awit_pkg::awit_bus_e         bus_q;      // idle or answering
  awit_pkg::awit_bus_e         bus_d;      // next bus state
  logic                        req;        // selected access present
  logic [2:0]                  idx;        // decoded register index
  logic                        wr_go;      // write commits at this edge
  logic                        rd_go;      // read commits at this edge
  logic                        launch;     // access seen while idle

  // read data path
  logic [awit_pkg::DATA_W-1:0] rd_byte;    // selected register value
  logic [awit_pkg::BUS_W-1:0]  dat_q;      // read data register
  logic [awit_pkg::BUS_W-1:0]  dat_d;      // next read data

  // control register
  awit_pkg::awit_ctrl_s        ctrl_q;     // timer_reset_control
  awit_pkg::awit_ctrl_s        ctrl_d;     // next control value

  // counter and prescaler
  logic                        tick;       // increment pulse
  logic [awit_pkg::DATA_W-1:0] count_q;    // tick_counter
  logic [awit_pkg::DATA_W-1:0] count_d;    // next count
  logic                        ovf;        // count wraps at this edge
  logic                        wd_evt;     // overflow in watchdog mode
  logic                        it_evt;     // overflow in interval mode

  // overflow flags, bit 0 watchdog, bit 1 interval
  logic [1:0]                  stat_q;     // sticky flags
  logic [1:0]                  stat_d;     // next flags
  logic [1:0]                  stat_set;   // set strobe per flag
  logic                        stat_clr;   // read-clear strobe
  awit_pkg::awit_stat_s        stat_view;  // status as seen on the bus

  // requests to the interrupt controller and power manager
  logic                        irq_q;      // timer_irq pulse
  logic                        irq_d;      // next timer_irq
  logic                        mrq_q;      // manual_reset_request pulse
  logic                        mrq_d;      // next manual request
  logic                        prq_q;      // poweron_reset_request pulse
  logic                        prq_d;      // next power-on request

  // an access counts only while cycle and strobe are both high
  assign req    = wb_cyc_i && wb_stb_i;  // see RULE_01
  assign idx    = reg_index(wb_adr_i);   // see RULE_07
  assign launch = req && (bus_q == awit_pkg::BUS_IDLE);

  // writes and reads take effect at the edge that sees ack high;
  // a write also needs the low byte lane
  assign wr_go  = req && wb_ack_o && wb_we_i &&
                  wb_sel_i[awit_pkg::LANE0];  // see RULE_02
  assign rd_go  = req && wb_ack_o && !wb_we_i;  // see RULE_02

  // bus sequencer: answer one cycle after the request is seen
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      awit_pkg::BUS_IDLE: begin
        if (req) begin  // see RULE_06
          bus_d = awit_pkg::BUS_ACK;
        end
      end
      awit_pkg::BUS_ACK: begin
        bus_d = awit_pkg::BUS_IDLE;  // ack drops after one cycle
      end
      default: begin
        bus_d = awit_pkg::BUS_IDLE;
      end
    endcase
  end

  // bus state register
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      bus_q <= awit_pkg::BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // ack is a decode of the state register
  assign wb_ack_o = (bus_q == awit_pkg::BUS_ACK);

  // status byte as software sees it, upper bits read as zero
  always_comb begin
    stat_view              = '0;
    stat_view.interval_ovf = stat_q[1];
    stat_view.watchdog_ovf = stat_q[0];
  end

  // register select, decoded from bits 4:2 only
  always_comb begin
    rd_byte = '0;  // unused indices read as zero
    if (idx == awit_pkg::IDX_CTRL) begin  // see RULE_07
      rd_byte = ctrl_q;
    end else if (idx == awit_pkg::IDX_STAT) begin
      rd_byte = stat_view;
    end else if (idx == awit_pkg::IDX_COUNT) begin
      rd_byte = count_q;
    end
  end

  // capture read data as the access is taken, so it stands with ack
  always_comb begin
    dat_d = dat_q;
    if (launch && !wb_we_i) begin  // see RULE_20
      dat_d = {{(awit_pkg::BUS_W-awit_pkg::DATA_W){1'b0}}, rd_byte};
    end
  end

  // read data register
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      dat_q <= '0;
    end else begin
      dat_q <= dat_d;
    end
  end

  // control register write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_go && idx == awit_pkg::IDX_CTRL) begin  // see RULE_20
      ctrl_d = awit_pkg::awit_ctrl_s'(wb_dat_i[awit_pkg::DATA_W-1:0]);
    end
  end

  // control register
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      ctrl_q <= awit_pkg::awit_ctrl_s'(awit_pkg::CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // rate divider, held cleared while counting is off
  awit_prescaler #(
    .W      (awit_pkg::PRESC_W)
  ) u_presc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (ctrl_q.count_enable_bit),  // see RULE_17
    .sel_i  (ctrl_q.prescale_select),   // see RULE_15
    .tick_o (tick)
  );

  // counter: a software write beats a tick in the same cycle
  always_comb begin
    count_d = count_q;
    ovf     = 1'b0;
    if (wr_go && idx == awit_pkg::IDX_COUNT) begin  // see RULE_21
      count_d = wb_dat_i[awit_pkg::DATA_W-1:0];
    end else if (tick && ctrl_q.count_enable_bit) begin  // see RULE_17
      count_d = count_q + awit_pkg::COUNT_ONE;
      ovf     = (count_q == awit_pkg::COUNT_MAX);  // see RULE_16
    end
  end

  // counter register
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      count_q <= awit_pkg::COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  // split the overflow by mode
  assign wd_evt = ovf &&
                  (ctrl_q.watchdog_mode_bit == awit_pkg::MODE_WATCHDOG);
  assign it_evt = ovf &&
                  (ctrl_q.watchdog_mode_bit != awit_pkg::MODE_WATCHDOG);
  assign stat_set = {it_evt, wd_evt};  // see RULE_14
  assign stat_clr = rd_go && (idx == awit_pkg::IDX_STAT);

  // sticky flags; a new overflow wins over a read-clear
  for (genvar g = 0; g < $bits(stat_q); g++) begin : g_flag
    assign stat_d[g] = stat_set[g] | (stat_q[g] & ~stat_clr);
  end

  // flag register
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      stat_q <= awit_pkg::STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // request pulses, one cycle per overflow
  always_comb begin
    irq_d = ovf && ctrl_q.irq_enable_bit;  // see RULE_10, RULE_19
    mrq_d = 1'b0;
    prq_d = 1'b0;
    if (wd_evt && ctrl_q.chip_reset_enable) begin  // see RULE_13, RULE_18
      if (ctrl_q.reset_type_select == awit_pkg::RSEL_MANUAL) begin
        mrq_d = 1'b1;  // see RULE_11
      end else begin
        prq_d = 1'b1;  // see RULE_12
      end
    end
  end

  // request registers
  always_ff @(posedge clk_i) begin  // see RULE_08
    if (rst_i) begin  // see RULE_09
      irq_q <= 1'b0;
      mrq_q <= 1'b0;
      prq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      mrq_q <= mrq_d;
      prq_q <= prq_d;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o                = dat_q;
  assign timer_irq_o             = irq_q;
  assign manual_reset_request_o  = mrq_q;
  assign poweron_reset_request_o = prq_q;

  // an overflow in watchdog mode with chip reset allowed
  sequence s_wd_reset;
    wd_evt && ctrl_q.chip_reset_enable;
  endsequence

  // the manual reset type is selected
  sequence s_sel_manual;
    ctrl_q.reset_type_select == awit_pkg::RSEL_MANUAL;
  endsequence

  // the power-on reset type is selected
  sequence s_sel_poweron;
    ctrl_q.reset_type_select != awit_pkg::RSEL_MANUAL;
  endsequence

  ack_pulse_a: assert property (  // see RULE_06
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("bus ack lasted two cycles");

  ack_prompt_a: assert property (  // see RULE_06
    @(posedge clk_i) disable iff (rst_i) launch |=> wb_ack_o)
    else $error("bus access not acknowledged");

  irq_gate_a: assert property (  // see RULE_19
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_q.irq_enable_bit |=> !timer_irq_o)
    else $error("interrupt raised while disabled");

  irq_raise_a: assert property (  // see RULE_10
    @(posedge clk_i) disable iff (rst_i)
    ovf && ctrl_q.irq_enable_bit |=> timer_irq_o)
    else $error("overflow interrupt missing");

  manual_req_a: assert property (  // see RULE_11
    @(posedge clk_i) disable iff (rst_i)
    s_wd_reset ##0 s_sel_manual
      |=> manual_reset_request_o && !poweron_reset_request_o)
    else $error("manual reset request wrong");

  poweron_req_a: assert property (  // see RULE_12
    @(posedge clk_i) disable iff (rst_i)
    s_wd_reset ##0 s_sel_poweron
      |=> poweron_reset_request_o && !manual_reset_request_o)
    else $error("power-on reset request wrong");

  interval_quiet_a: assert property (  // see RULE_14
    @(posedge clk_i) disable iff (rst_i)
    it_evt |=> !manual_reset_request_o && !poweron_reset_request_o)
    else $error("reset request in interval mode");

  count_write_a: assert property (  // see RULE_21
    @(posedge clk_i) disable iff (rst_i)
    wr_go && idx == awit_pkg::IDX_COUNT
      |=> count_q == $past(wb_dat_i[awit_pkg::DATA_W-1:0]))
    else $error("counter write did not land");

  count_reset_a: assert property (  // see RULE_09
    @(posedge clk_i) rst_i |=> count_q == awit_pkg::COUNT_RST)
    else $error("counter not cleared by reset");

endmodule : awit_timer

// File: tb/awit_sink.sv
`timescale 1ns/1ps
// interrupt controller and power manager: latch every request seen
module awit_sink (
  // clock and clear
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  // irq, manual, power-on
  input  wire logic [2:0] req_i,
  output logic      [2:0] seen_o
);
  // a short pulse is not lost before the bench looks
  always_ff @(posedge clk_i) begin
    seen_o <= clr_i ? 3'h0 : (seen_o | req_i);
  end
endmodule : awit_sink

// File: tb/awit_timer_bench.sv
`timescale 1ns/1ps
module awit_timer_bench;
  logic        clk = 1'b0;  // 100 MHz bus clock
  logic        rst = 1'b1;  // synchronous reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b1;
  logic [31:0] adr = '0, wdat = '0, rdat;
  logic [7:0]  q;           // last byte read
  logic        ack, irq, mrq, prq;
  logic [2:0]  seen;        // requests latched by the sink
  int          t, fails = 0, n_tests = 0;
  int          dv[8] = '{2, 8, 32, 64, 256, 512, 2048, 8192};
  always #5 clk = ~clk;
  awit_timer dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer_irq_o(irq),
    .manual_reset_request_o(mrq), .poweron_reset_request_o(prq));
  awit_sink sink (.clk_i(clk), .clr_i(clr), .req_i({irq, mrq, prq}),
    .seen_o(seen));
  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic bus cycle held until ack
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {27'h000_0000, a};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat[7:0];
    chk({7'h00, ack}, 8'h01);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  // stop, clear flags, preload count, start, wait for the requests
  task automatic run(input logic [7:0] c, input logic [7:0] cnt,
                     input logic [2:0] exp, input logic [7:0] st);
    bus(1'b1, awit_pkg::OFF_CTRL, 8'h00);
    bus(1'b0, awit_pkg::OFF_STAT, 8'h00);
    bus(1'b1, awit_pkg::OFF_COUNT, cnt);
    clr <= 1'b0;
    bus(1'b1, awit_pkg::OFF_CTRL, c);
    t = 0;
    while (t < 20000 && !(exp != 3'h0 && seen === exp)) begin
      @(posedge clk);
      t++;
    end
    chk({5'h00, seen}, {5'h00, exp});
    bus(1'b1, awit_pkg::OFF_CTRL, 8'h00);
    bus(1'b0, awit_pkg::OFF_STAT, 8'h00);
    chk(q, st);
    clr <= 1'b1;
  endtask : run
  // report and end the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, awit_pkg::OFF_COUNT, 8'h00);
    chk(q, awit_pkg::COUNT_RST);
    bus(1'b1, awit_pkg::OFF_CTRL, 8'h5a);
    bus(1'b0, awit_pkg::OFF_CTRL, 8'h00);
    chk(q, 8'h5a);
    run(8'hf0, 8'hfe, 3'h5, 8'h01);
    run(8'hf8, 8'hfe, 3'h6, 8'h01);
    run(8'he0, 8'hfe, 3'h4, 8'h01);
    run(8'h60, 8'hfe, 3'h0, 8'h01);
    for (int i = 0; i < 8; i++) begin
      run({5'h14, i[2:0]}, 8'hfe, 3'h4, 8'h02);
      chk({7'h00, t >= dv[i] && t <= 2 * dv[i] + 8}, 8'h01);
    end
    stop_test();
  end
  // watchdog against a hang
  initial begin
    #1_000_000;
    fails++;
    stop_test();
  end
endmodule : awit_timer_bench
